// >>> core/sas_adc_sequencer.sv
`timescale 1ns/1ps
// Contract
// R01 - sample channel, then hold until done
// R02 - first trial sets bit 9, half tap
// R03 - bit 9 kept if at or above half
// R04 - bit 8 trial, tap from bit 9
// R05 - trial bit kept when input >= tap
// R06 - repeat down to bit 0, ten compares
// R07 - copy result into high/low registers
// R08 - end irq raised with result latch
// R09 - start bit self-clears, back to standby
// R10 - one conversion per start write
// R11 - reset clears both result registers
// R12 - high holds top eight, low two
// R13 - combined result is approximation times 64
// R14 - enable from stopped gives standby
// R15 - software waits stabilization before start
// R16 - start cleared mid-run aborts conversion
// R17 - enable cleared in standby stops converter
// R18 - software never starts with enable low
// R19 - start while stopped is ignored
// R20 - resolution bit picks 10 or 8 bits
// R21 - three-bit channel select of eight
// R22 - 8-bit mode low result reads zero
// R23 - steps paced by divided clock, sampling first
module sas_adc_sequencer
  import sas_pkg::*;
#(
  parameter int SAMPLE_PERIODS = SAS_SAMPLE_PERIODS,
  parameter int STEP_BASE = SAS_STEP_BASE
) (
  input logic aclk,
  input logic aresetn,
  input logic [SAS_ADDR_W-1:0] s_axi_awaddr,
  input logic s_axi_awvalid,
  output logic s_axi_awready,
  input logic [SAS_DATA_W-1:0] s_axi_wdata,
  input logic [3:0] s_axi_wstrb,
  input logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic [SAS_ADDR_W-1:0] s_axi_araddr,
  input logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [SAS_DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input logic s_axi_rready,
  input logic comp_ge_pin,
  output logic [SAS_CH_W-1:0] channel_sel,
  output logic sample_en,
  output logic hold_en,
  output logic [SAS_SAR_W-1:0] tap_code,
  output logic conversion_end_irq
);

  sas_conv_if conv ();

  // bus slave state
  logic awready_q;
  logic wready_q;
  logic aw_full_q;
  logic w_full_q;
  logic [SAS_ADDR_W-1:0] awaddr_q;
  logic [SAS_DATA_W-1:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic arready_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [SAS_DATA_W-1:0] rdata_q;

  // converter control
  logic enable_q;
  logic start_q;
  logic go_q;
  logic [SAS_DIV_W-1:0] div_q;
  logic res8_q;
  logic [SAS_CH_W-1:0] chsel_q;
  logic [SAS_HIGH_W-1:0] res_high_q;
  logic [SAS_LOW_W-1:0] res_low_q;
  logic done_flag_q;
  logic irq_q;
  logic comp_s1_q;
  logic comp_s2_q;

  logic wr_fire;
  sas_sel_e wr_sel;
  logic wr_lane0;
  logic wr_mode0;
  logic wr_mode2;
  logic wr_chsel;
  logic wr_status;
  logic wr_ok;
  logic latch_result;
  sas_cvt_e cvt_state;
  logic [SAS_DATA_W-1:0] rd_word;
  logic rd_ok;

  // ---- write channel ----
  assign wr_fire = aw_full_q && w_full_q && !bvalid_q;
  assign wr_sel = sas_decode(awaddr_q);
  assign wr_lane0 = wstrb_q[0];
  assign wr_mode0 = wr_fire && wr_lane0 && (wr_sel == SAS_SEL_MODE0);
  assign wr_mode2 = wr_fire && wr_lane0 && (wr_sel == SAS_SEL_MODE2);
  assign wr_chsel = wr_fire && wr_lane0 && (wr_sel == SAS_SEL_CHSEL);
  assign wr_status = wr_fire && wr_lane0 && (wr_sel == SAS_SEL_STATUS);
  assign wr_ok = (wr_sel == SAS_SEL_MODE0) || (wr_sel == SAS_SEL_MODE2)
    || (wr_sel == SAS_SEL_CHSEL) || (wr_sel == SAS_SEL_STATUS);

  // address and data are captured independently, in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b0;
      aw_full_q <= 1'b0;
      awaddr_q <= '0;
    end else if (s_axi_awvalid && awready_q) begin
      awready_q <= 1'b0;
      aw_full_q <= 1'b1;
      awaddr_q <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_full_q <= 1'b0;
    end else if (!aw_full_q && !bvalid_q) begin
      awready_q <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready_q <= 1'b0;
      w_full_q <= 1'b0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else if (s_axi_wvalid && wready_q) begin
      wready_q <= 1'b0;
      w_full_q <= 1'b1;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_full_q <= 1'b0;
    end else if (!w_full_q && !bvalid_q) begin
      wready_q <= 1'b1;
    end
  end

  // read-only and unmapped words answer slverr and change nothing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= SAS_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_ok ? SAS_RESP_OKAY : SAS_RESP_SLVERR;
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // ---- converter mode and start control ----
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enable_q <= 1'b0;
      start_q <= 1'b0;
      go_q <= 1'b0;
      div_q <= SAS_DIV_RST;
    end else begin
      go_q <= 1'b0;
      if (wr_mode0) begin
        enable_q <= wdata_q[SAS_EN_BIT]; // R14 R17
        div_q <= wdata_q[SAS_DIV_LSB +: SAS_DIV_W];
        // a start needs the converter already enabled; a set bit is not re-armed
        if (wdata_q[SAS_START_BIT] && wdata_q[SAS_EN_BIT] && enable_q && !start_q) begin
          start_q <= 1'b1; // R10 R19
          go_q <= 1'b1; // R10
        // an end that the write suppresses must still free the start bit
        end else if (!wdata_q[SAS_START_BIT] || !wdata_q[SAS_EN_BIT] || conv.done) begin
          start_q <= 1'b0; // R09 R16 R18
        end
      end else if (conv.done) begin
        start_q <= 1'b0; // R09
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      res8_q <= 1'b0;
    end else if (wr_mode2) begin
      res8_q <= wdata_q[SAS_RES_BIT]; // R20
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chsel_q <= SAS_CH_RST;
    end else if (wr_chsel) begin
      chsel_q <= wdata_q[SAS_CH_W-1:0]; // R21
    end
  end

  // ---- result capture ----
  // a mode write landing on the end cycle wins: no latch, no irq
  assign latch_result = conv.done && !wr_mode0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      res_high_q <= SAS_RESH_RST; // R11
      res_low_q <= SAS_RESL_RST; // R11
    end else if (latch_result) begin
      res_high_q <= conv.result[SAS_SAR_W-1 -: SAS_HIGH_W]; // R07 R12
      res_low_q <= res8_q ? SAS_RESL_RST : conv.result[SAS_LOW_W-1:0]; // R12 R22
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= latch_result; // R08
    end
  end

  // sticky end flag, write one to clear; a new end wins over the clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done_flag_q <= 1'b0;
    end else if (latch_result) begin
      done_flag_q <= 1'b1;
    end else if (wr_status && wdata_q[SAS_ST_FLAG]) begin
      done_flag_q <= 1'b0;
    end
  end

  // comparator decision is asynchronous to aclk
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      comp_s1_q <= 1'b0;
      comp_s2_q <= 1'b0;
    end else begin
      comp_s1_q <= comp_ge_pin;
      comp_s2_q <= comp_s1_q;
    end
  end

  // ---- engine ----
  assign conv.go = go_q;
  assign conv.run = start_q;
  assign conv.res8 = res8_q;
  assign conv.div_sel = div_q;
  assign conv.comp_ge = comp_s2_q;

  // the engine period must cover the two-flop comparator delay
  sas_sar_engine #(
    .SAMPLE_PERIODS(SAMPLE_PERIODS),
    .STEP_BASE(STEP_BASE)
  ) u_engine (
    .aclk(aclk),
    .aresetn(aresetn),
    .conv(conv.engine)
  );

  // ---- read channel ----
  always_comb begin
    if (!enable_q) begin
      cvt_state = SAS_CVT_STOPPED; // R17
    end else if (start_q) begin
      cvt_state = SAS_CVT_RUNNING;
    end else begin
      cvt_state = SAS_CVT_STANDBY; // R14
    end
  end

  always_comb begin
    rd_word = '0;
    rd_ok = 1'b1;
    case (sas_decode(s_axi_araddr))
      SAS_SEL_MODE0: begin
        rd_word[SAS_EN_BIT] = enable_q;
        rd_word[SAS_DIV_LSB +: SAS_DIV_W] = div_q;
        rd_word[SAS_START_BIT] = start_q;
      end
      SAS_SEL_MODE2: begin
        rd_word[SAS_RES_BIT] = res8_q;
      end
      SAS_SEL_CHSEL: begin
        rd_word[SAS_CH_W-1:0] = chsel_q; // R21
      end
      SAS_SEL_RESH: begin
        rd_word[SAS_HIGH_W-1:0] = res_high_q; // R12
      end
      SAS_SEL_RESL: begin
        rd_word[SAS_RESL_LSB +: SAS_LOW_W] = res_low_q; // R12
      end
      SAS_SEL_COMB: begin
        rd_word = SAS_DATA_W'({res_high_q, res_low_q, SAS_COMB_PAD}); // R13
      end
      SAS_SEL_STATUS: begin
        rd_word[SAS_ST_FLAG] = done_flag_q;
        rd_word[SAS_ST_STATE_LSB +: 2] = cvt_state;
        rd_word[SAS_ST_SAMP] = conv.sampling;
        rd_word[SAS_ST_HOLD] = conv.hold;
      end
      default: begin
        rd_ok = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rresp_q <= SAS_RESP_OKAY;
      rdata_q <= '0;
    end else if (s_axi_arvalid && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rresp_q <= rd_ok ? SAS_RESP_OKAY : SAS_RESP_SLVERR;
      rdata_q <= rd_word;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end else if (!rvalid_q) begin
      arready_q <= 1'b1;
    end
  end

  // ---- outputs ----
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;
  assign channel_sel = chsel_q; // R21
  assign sample_en = conv.sampling; // R01
  assign hold_en = conv.hold; // R01
  assign tap_code = conv.tap; // R02 R04
  assign conversion_end_irq = irq_q; // R08

endmodule

// >>> core/sas_pkg.sv
package sas_pkg;

  localparam int SAS_ADDR_W = 8;
  localparam int SAS_DATA_W = 32;
  localparam int SAS_SAR_W = 10;
  localparam int SAS_HIGH_W = 8;
  localparam int SAS_LOW_W = 2;
  localparam int SAS_CH_W = 3;
  localparam int SAS_DIV_W = 2;
  localparam int SAS_CNT_W = 6;

  // register byte addresses
  localparam logic [SAS_ADDR_W-1:0] SAS_OFF_MODE0 = 8'h00;
  localparam logic [SAS_ADDR_W-1:0] SAS_OFF_MODE2 = 8'h04;
  localparam logic [SAS_ADDR_W-1:0] SAS_OFF_CHSEL = 8'h08;
  localparam logic [SAS_ADDR_W-1:0] SAS_OFF_RESH = 8'h0C;
  localparam logic [SAS_ADDR_W-1:0] SAS_OFF_RESL = 8'h10;
  localparam logic [SAS_ADDR_W-1:0] SAS_OFF_COMB = 8'h14;
  localparam logic [SAS_ADDR_W-1:0] SAS_OFF_STATUS = 8'h18;

  // field positions
  localparam int SAS_START_BIT = 7;
  localparam int SAS_EN_BIT = 0;
  localparam int SAS_DIV_LSB = 1;
  localparam int SAS_RES_BIT = 0;
  localparam int SAS_RESL_LSB = 6;
  localparam int SAS_ST_FLAG = 0;
  localparam int SAS_ST_STATE_LSB = 1;
  localparam int SAS_ST_SAMP = 3;
  localparam int SAS_ST_HOLD = 4;

  // reset values and fixed patterns
  localparam logic [SAS_HIGH_W-1:0] SAS_RESH_RST = 8'h00;
  localparam logic [SAS_LOW_W-1:0] SAS_RESL_RST = 2'h0;
  localparam logic [SAS_DIV_W-1:0] SAS_DIV_RST = 2'h0;
  localparam logic [SAS_CH_W-1:0] SAS_CH_RST = 3'h0;
  localparam logic [5:0] SAS_COMB_PAD = 6'h00;
  localparam logic [SAS_SAR_W-1:0] SAS_SAR_ZERO = 10'h000;

  // conversion pacing
  localparam int SAS_SAMPLE_PERIODS = 3;
  localparam int SAS_STEP_BASE = 4;
  localparam logic [3:0] SAS_MSB_IDX = 4'h9;
  localparam logic [3:0] SAS_LAST_10 = 4'h0;
  localparam logic [3:0] SAS_LAST_8 = 4'h2;

  localparam logic [1:0] SAS_RESP_OKAY = 2'h0;
  localparam logic [1:0] SAS_RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    SAS_SEL_NONE, SAS_SEL_MODE0, SAS_SEL_MODE2, SAS_SEL_CHSEL,
    SAS_SEL_RESH, SAS_SEL_RESL, SAS_SEL_COMB, SAS_SEL_STATUS
  } sas_sel_e;

  typedef enum logic [1:0] {SAS_CVT_STOPPED, SAS_CVT_STANDBY, SAS_CVT_RUNNING} sas_cvt_e;

  typedef enum logic [1:0] {SAS_ENG_IDLE, SAS_ENG_SAMPLE, SAS_ENG_COMPARE} sas_eng_e;

  function automatic sas_sel_e sas_decode(input logic [SAS_ADDR_W-1:0] addr);
    case (addr)
      SAS_OFF_MODE0: sas_decode = SAS_SEL_MODE0;
      SAS_OFF_MODE2: sas_decode = SAS_SEL_MODE2;
      SAS_OFF_CHSEL: sas_decode = SAS_SEL_CHSEL;
      SAS_OFF_RESH: sas_decode = SAS_SEL_RESH;
      SAS_OFF_RESL: sas_decode = SAS_SEL_RESL;
      SAS_OFF_COMB: sas_decode = SAS_SEL_COMB;
      SAS_OFF_STATUS: sas_decode = SAS_SEL_STATUS;
      default: sas_decode = SAS_SEL_NONE;
    endcase
  endfunction

  function automatic logic [SAS_SAR_W-1:0] sas_bit(input logic [3:0] idx);
    sas_bit = SAS_SAR_ZERO;
    sas_bit[idx] = 1'b1;
  endfunction

endpackage

// >>> core/sas_conv_if.sv
`timescale 1ns/1ps
interface sas_conv_if;
  import sas_pkg::*;
  logic go;
  logic run;
  logic res8;
  logic [SAS_DIV_W-1:0] div_sel;
  logic comp_ge;
  logic sampling;
  logic hold;
  logic done;
  logic [SAS_SAR_W-1:0] result;
  logic [SAS_SAR_W-1:0] tap;
  modport ctrl (output go, run, res8, div_sel, comp_ge,
    input sampling, hold, done, result, tap);
  modport engine (input go, run, res8, div_sel, comp_ge,
    output sampling, hold, done, result, tap);
endinterface

// >>> core/sas_sar_engine.sv
`timescale 1ns/1ps
module sas_sar_engine
  import sas_pkg::*;
#(
  parameter int SAMPLE_PERIODS = SAS_SAMPLE_PERIODS,
  parameter int STEP_BASE = SAS_STEP_BASE
) (
  input logic aclk,
  input logic aresetn,
  sas_conv_if.engine conv
);

  sas_eng_e state_q;
  logic [SAS_CNT_W-1:0] cnt_q;
  logic [SAS_CNT_W-1:0] period;
  logic tick;
  logic [SAS_CNT_W-1:0] samp_q;
  logic [3:0] idx_q;
  logic [3:0] last_idx;
  logic [SAS_SAR_W-1:0] sar_q;
  logic [SAS_SAR_W-1:0] decided;
  logic [SAS_SAR_W-1:0] result_q;
  logic sampling_q;
  logic hold_q;
  logic done_q;

  // one conversion-clock period, base cycles scaled by the divider
  assign period = SAS_CNT_W'(STEP_BASE) << conv.div_sel; // R23
  assign tick = (cnt_q == period - 1'b1);
  assign last_idx = conv.res8 ? SAS_LAST_8 : SAS_LAST_10; // R20
  // trial bit stays set only when input is at or above the tap
  assign decided = conv.comp_ge ? sar_q : (sar_q & ~sas_bit(idx_q)); // R03 R05

  always_ff @(posedge aclk) begin
    if (!aresetn || state_q == SAS_ENG_IDLE || tick) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= SAS_ENG_IDLE;
      samp_q <= '0;
      idx_q <= SAS_MSB_IDX;
      sar_q <= SAS_SAR_ZERO;
      result_q <= SAS_SAR_ZERO;
      sampling_q <= 1'b0;
      hold_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      case (state_q)
        SAS_ENG_IDLE: begin
          if (conv.go) begin
            state_q <= SAS_ENG_SAMPLE;
            samp_q <= '0;
            sampling_q <= 1'b1; // R01
            hold_q <= 1'b0;
          end
        end
        SAS_ENG_SAMPLE: begin
          if (!conv.run) begin
            state_q <= SAS_ENG_IDLE; // R16
            sampling_q <= 1'b0;
          end else if (tick) begin
            if (samp_q == SAS_CNT_W'(SAMPLE_PERIODS - 1)) begin
              state_q <= SAS_ENG_COMPARE;
              sampling_q <= 1'b0;
              hold_q <= 1'b1; // R01
              idx_q <= SAS_MSB_IDX;
              sar_q <= sas_bit(SAS_MSB_IDX); // R02
            end else begin
              samp_q <= samp_q + 1'b1; // R23
            end
          end
        end
        SAS_ENG_COMPARE: begin
          if (!conv.run) begin
            state_q <= SAS_ENG_IDLE; // R16
            hold_q <= 1'b0;
          end else if (tick) begin
            if (idx_q == last_idx) begin
              sar_q <= decided;
              result_q <= decided;
              done_q <= 1'b1;
              hold_q <= 1'b0;
              state_q <= SAS_ENG_IDLE;
            end else begin
              sar_q <= decided | sas_bit(idx_q - 1'b1); // R04 R06
              idx_q <= idx_q - 1'b1; // R06
            end
          end
        end
        default: begin
          state_q <= SAS_ENG_IDLE;
        end
      endcase
    end
  end

  assign conv.sampling = sampling_q;
  assign conv.hold = hold_q;
  assign conv.done = done_q;
  assign conv.result = result_q;
  assign conv.tap = sar_q;

endmodule

// >>> verification/sas_adc_chk.sv
`timescale 1ns/1ps
module sas_adc_chk
  import sas_pkg::*;
#(
  parameter int SAMPLE_PERIODS = SAS_SAMPLE_PERIODS,
  parameter int STEP_BASE = SAS_STEP_BASE
) (
  input logic aclk,
  input logic aresetn,
  input logic s_axi_arvalid,
  input logic s_axi_arready,
  input logic s_axi_rvalid,
  input logic s_axi_rready,
  input logic [SAS_DATA_W-1:0] s_axi_rdata,
  input logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic [1:0] s_axi_bresp,
  input logic sample_en,
  input logic hold_en,
  input logic [SAS_SAR_W-1:0] tap_code,
  input logic conversion_end_irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [SAS_SAR_W-1:0] prev_tap_q;
  logic prev_hold_q;
  logic [SAS_SAR_W-1:0] tap_lsb;
  always_ff @(posedge aclk) begin
    prev_tap_q <= tap_code;
    prev_hold_q <= hold_en;
  end
  // lowest set bit of the previous tap is the trial being decided
  assign tap_lsb = prev_tap_q & (~prev_tap_q + 10'h001);
  sequence s_done_pulse;
    conversion_end_irq ##1 !conversion_end_irq;
  endsequence
  sequence s_enter_hold;
    $fell(sample_en) ##0 (tap_code == 10'h200);
  endsequence
  a_irq_one_cycle: assert property ($rose(conversion_end_irq) |-> s_done_pulse)
    else $error("end irq longer than one cycle");
  a_hold_after_sample: assert property ($rose(hold_en) |-> s_enter_hold)
    else $error("hold entered without sampling or half tap");
  a_sample_hold_apart: assert property (!(sample_en && hold_en))
    else $error("sample and hold both on");
  a_tap_trial_step: assert property (hold_en && prev_hold_q && tap_code != prev_tap_q
      && tap_code != 10'h000 |-> tap_code == ((prev_tap_q & ~tap_lsb) | (tap_lsb >> 1))
      || tap_code == (prev_tap_q | (tap_lsb >> 1)))
    else $error("tap moved other than one trial step");
  a_sample_min_len: assert property ($rose(sample_en) |-> sample_en [*8])
    else $error("sampling shorter than minimum");
  a_irq_idle_end: assert property (conversion_end_irq |-> !hold_en && !sample_en)
    else $error("end irq while converting");
  a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
endmodule
bind sas_adc_sequencer sas_adc_chk #(.SAMPLE_PERIODS(SAMPLE_PERIODS), .STEP_BASE(STEP_BASE))
  sas_adc_chk_inst (.aclk, .aresetn, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .s_axi_rdata, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .sample_en,
  .hold_en, .tap_code, .conversion_end_irq);

// >>> verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import sas_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [SAS_ADDR_W-1:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, comp_ge_pin = 1'b0;
  logic [SAS_DATA_W-1:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic sample_en, hold_en, conversion_end_irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [SAS_DATA_W-1:0] s_axi_rdata, rd;
  logic [SAS_CH_W-1:0] channel_sel;
  logic [SAS_SAR_W-1:0] tap_code;
  logic [SAS_SAR_W-1:0] vin_q [8];
  int err_total = 0;
  int num_checks = 0;
  always #2.5 aclk = ~aclk;
  sas_adc_sequencer sas_adc_sequencer_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .comp_ge_pin, .channel_sel,
    .sample_en, .hold_en, .tap_code, .conversion_end_irq);
  // ideal comparator on the selected input, one cycle behind the tap
  always @(posedge aclk) comp_ge_pin <= vin_q[channel_sel] >= tap_code;
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t word %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t resp %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready === 1'b1) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready === 1'b1) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // counts end pulses over a fixed window, long enough for the slowest divider
  task automatic wait_irq(input int lim, output int seen);
    seen = 0;
    repeat (lim) begin
      @(posedge aclk);
      #1;
      if (conversion_end_irq === 1'b1) seen++;
    end
  endtask
  task automatic t_regs;
    axi_read(SAS_OFF_RESH, rd, rsp);
    chk_word(rd, 32'h0000_0000);
    axi_read(SAS_OFF_RESL, rd, rsp);
    chk_word(rd, 32'h0000_0000);
    axi_write(SAS_OFF_RESH, 32'h0000_00FF, rsp);
    chk_resp(rsp, SAS_RESP_SLVERR);
    axi_read(8'h1C, rd, rsp);
    chk_resp(rsp, SAS_RESP_SLVERR);
    axi_write(8'h1C, 32'h0000_0001, rsp);
    chk_resp(rsp, SAS_RESP_SLVERR);
  endtask
  task automatic t_convert(input logic [2:0] ch, input logic [9:0] v, input logic res8,
      input logic [1:0] dv);
    logic [9:0] exp;
    int seen;
    exp = res8 ? {v[9:2], 2'b00} : v;
    vin_q[ch] = v;
    axi_write(SAS_OFF_MODE0, 32'h0000_0000, rsp);
    axi_write(SAS_OFF_CHSEL, {29'h0, ch}, rsp);
    axi_write(SAS_OFF_MODE2, {31'h0, res8}, rsp);
    axi_write(SAS_OFF_MODE0, {29'h0, dv, 1'b1}, rsp);
    repeat (20) @(posedge aclk);
    axi_write(SAS_OFF_MODE0, {24'h0, 1'b1, 4'h0, dv, 1'b1}, rsp);
    chk_resp(rsp, SAS_RESP_OKAY);
    chk_word({29'h0, channel_sel}, {29'h0, ch});
    wait_irq(600, seen);
    chk_word(32'(seen), 32'h1);
    axi_read(SAS_OFF_RESH, rd, rsp);
    chk_word(rd, {24'h0, exp[9:2]});
    axi_read(SAS_OFF_RESL, rd, rsp);
    chk_word(rd, {24'h0, exp[1:0], 6'h00});
    axi_read(SAS_OFF_COMB, rd, rsp);
    chk_word(rd, {16'h0, exp, 6'h00});
    axi_read(SAS_OFF_MODE0, rd, rsp);
    chk_word(rd, {24'h0, 1'b0, 4'h0, dv, 1'b1});
    axi_read(SAS_OFF_STATUS, rd, rsp);
    chk_word(rd & 32'h0000_0006, 32'h0000_0002);
    chk_word(rd & 32'h0000_0001, 32'h0000_0001);
    axi_write(SAS_OFF_STATUS, 32'h0000_0001, rsp);
    chk_resp(rsp, SAS_RESP_OKAY);
    axi_read(SAS_OFF_STATUS, rd, rsp);
    chk_word(rd & 32'h0000_0001, 32'h0000_0000);
  endtask
  task automatic t_abort;
    int seen;
    int k;
    axi_write(SAS_OFF_MODE0, 32'h0000_0081, rsp);
    for (k = 0; k < 200 && hold_en !== 1'b1; k++) @(posedge aclk);
    axi_read(SAS_OFF_STATUS, rd, rsp);
    chk_word(rd & 32'h0000_001E, 32'h0000_0014);
    axi_write(SAS_OFF_MODE0, 32'h0000_0001, rsp);
    wait_irq(600, seen);
    chk_word(32'(seen), 32'h0);
    axi_read(SAS_OFF_COMB, rd, rsp);
    chk_word(rd, 32'h0000_6D80);
    axi_read(SAS_OFF_STATUS, rd, rsp);
    chk_word(rd & 32'h0000_0006, 32'h0000_0002);
  endtask
  task automatic t_stop_ignore;
    int seen;
    axi_write(SAS_OFF_MODE0, 32'h0000_0000, rsp);
    axi_read(SAS_OFF_STATUS, rd, rsp);
    chk_word(rd & 32'h0000_0006, 32'h0000_0000);
    axi_write(SAS_OFF_MODE0, 32'h0000_0001, rsp);
    axi_read(SAS_OFF_STATUS, rd, rsp);
    chk_word(rd & 32'h0000_0006, 32'h0000_0002);
    axi_write(SAS_OFF_MODE0, 32'h0000_0000, rsp);
    // enable and start in one write from stopped: start is ignored
    axi_write(SAS_OFF_MODE0, 32'h0000_0081, rsp);
    wait_irq(300, seen);
    chk_word(32'(seen), 32'h0);
    axi_read(SAS_OFF_STATUS, rd, rsp);
    chk_word(rd & 32'h0000_0006, 32'h0000_0002);
    axi_read(SAS_OFF_MODE0, rd, rsp);
    chk_word(rd, 32'h0000_0001);
  endtask
  initial begin
    foreach (vin_q[i]) vin_q[i] = 10'h000;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_regs();
    t_convert(3'h0, 10'h3FF, 1'b0, 2'h0);
    t_convert(3'h5, 10'h000, 1'b0, 2'h3);
    t_convert(3'h7, 10'h2A5, 1'b1, 2'h1);
    t_convert(3'h3, 10'h1B6, 1'b0, 2'h2);
    t_abort();
    t_stop_ignore();
    wrap_up();
  end
  initial begin
    #100000;
    err_total++;
    $display("[FAIL] %0t watchdog expired", $time);
    wrap_up();
  end
endmodule
